// file: hdl/cie_pkg.sv
`default_nettype none
package cie_pkg;
   // Restart target taken on a non-maskable acceptance
   localparam logic [15:0] CIE_NMI_VECTOR   = 16'h0066;
   // Reset values of the enable flops (disabled)
   localparam logic        CIE_ENABLE_RESET = 1'b0;
   // Instruction codes on the decoded instruction port
   localparam int          CIE_OP_W         = 3;
   localparam logic [2:0]  CIE_OP_NONE      = 3'h0;
   localparam logic [2:0]  CIE_OP_ENABLE    = 3'h1;
   localparam logic [2:0]  CIE_OP_DISABLE   = 3'h2;
   localparam logic [2:0]  CIE_OP_NMI_RETURN = 3'h3;
   localparam logic [2:0]  CIE_OP_LD_VBASE  = 3'h4;
   localparam logic [2:0]  CIE_OP_LD_REFR   = 3'h5;
   localparam logic [2:0]  CIE_OP_OTHER     = 3'h6;
   // Synchroniser depth for the request pins
   localparam int          CIE_SYNC_STAGES  = 2;
   typedef enum logic [2:0] {
      CIE_ST_RUN   = 3'b001,
      CIE_ST_NMI   = 3'b010,
      CIE_ST_INT   = 3'b100
   } cie_state_e;
endpackage
`default_nettype wire

// file: hdl/cie_sync.sv
`default_nettype none
module cie_sync
   import cie_pkg::*;
#(
   parameter int STAGES = CIE_SYNC_STAGES
) (
   input  wire logic clk,
   input  wire logic rst,
   input  wire logic din,
   output logic      dout
);
   logic [STAGES-1:0] sh_r;
   logic [STAGES-1:0] sh_nxt;

   // A single stage would leave metastability on the logic side
   if (STAGES < 2) begin : g_bad_depth
      $error("cie_sync needs at least two stages");
   end

   always_comb begin
      sh_nxt = {sh_r[STAGES-2:0], din};
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         sh_r <= '0;
      end else begin
         sh_r <= sh_nxt;
      end
   end

   assign dout = sh_r[STAGES-1];
endmodule
`default_nettype wire

// file: hdl/cie_enable_logic.sv
`default_nettype none
module cie_enable_logic
   import cie_pkg::*;
(
   input  wire logic                clk,
   input  wire logic                rst,
   input  wire logic                int_req_n,
   input  wire logic                nmi_req_n,
   input  wire logic                instr_done,
   input  wire logic [CIE_OP_W-1:0] instr_op,
   output logic                     int_enable_primary,
   output logic                     int_enable_shadow,
   output logic                     accept_nmi,
   output logic                     accept_int,
   output logic [15:0]              restart_addr,
   output logic                     restart_valid,
   output logic                     parity_flag,
   output logic                     parity_load
);
   logic       int_req_s;
   logic       nmi_req_s;
   logic       nmi_prev_r;
   logic       nmi_prev_nxt;
   logic       nmi_pend_r;
   logic       nmi_pend_nxt;
   logic       pri_r;
   logic       pri_nxt;
   logic       shd_r;
   logic       shd_nxt;
   logic       en_hold_r;
   logic       en_hold_nxt;
   logic [1:0] bnd_cnt_r;
   logic [1:0] bnd_cnt_nxt;
   logic       par_r;
   logic       par_nxt;
   logic       par_ld_r;
   logic       par_ld_nxt;
   logic [15:0] rst_addr_r;
   logic [15:0] rst_addr_nxt;
   logic       rst_vld_r;
   logic       rst_vld_nxt;
   cie_state_e state_r;
   cie_state_e state_nxt;
   logic       take_nmi;
   logic       take_int;

   function automatic logic is_acc_load(input logic [CIE_OP_W-1:0] op);
      is_acc_load = (op == CIE_OP_LD_VBASE) || (op == CIE_OP_LD_REFR);
   endfunction

   // Decode assumes three opcode bits and a real two-flop pin stage
   if (CIE_OP_W != 3 || CIE_SYNC_STAGES < 2) begin : g_bad_cfg
      $error("cie_enable_logic: unsupported opcode width or sync depth");
   end

   // Request pins come from peripherals, off this clock
   cie_sync #(.STAGES(CIE_SYNC_STAGES)) u_sync_int (
      .clk  (clk),
      .rst  (rst),
      .din  (~int_req_n),
      .dout (int_req_s)
   );
   cie_sync #(.STAGES(CIE_SYNC_STAGES)) u_sync_nmi (
      .clk  (clk),
      .rst  (rst),
      .din  (~nmi_req_n),
      .dout (nmi_req_s)
   );

   assign take_nmi = instr_done && (nmi_pend_r || (nmi_req_s && !nmi_prev_r));
   assign take_int = instr_done && !take_nmi && int_req_s && pri_r && !en_hold_r
                     && (instr_op != CIE_OP_ENABLE);

   always_comb begin
      // Edge caught any time so a short pulse is not lost before a boundary
      nmi_prev_nxt = nmi_req_s;
      nmi_pend_nxt = nmi_pend_r;
      if (nmi_req_s && !nmi_prev_r) begin
         nmi_pend_nxt = 1'b1;
      end
      if (take_nmi) begin
         nmi_pend_nxt = 1'b0;
      end
   end

   always_comb begin
      pri_nxt     = pri_r;
      shd_nxt     = shd_r;
      en_hold_nxt = en_hold_r;
      par_nxt     = par_r;
      par_ld_nxt  = 1'b0;
      state_nxt   = CIE_ST_RUN;
      if (instr_done) begin
         en_hold_nxt = 1'b0;
         case (instr_op)
            CIE_OP_ENABLE: begin
               pri_nxt     = 1'b1;
               shd_nxt     = 1'b1;
               en_hold_nxt = 1'b1;
            end
            CIE_OP_DISABLE: begin
               pri_nxt = 1'b0;
               shd_nxt = 1'b0;
            end
            CIE_OP_NMI_RETURN: begin
               pri_nxt = shd_r;
            end
            default: begin
               pri_nxt = pri_r;
            end
         endcase
         if (is_acc_load(instr_op)) begin
            par_nxt    = shd_r;
            par_ld_nxt = 1'b1;
         end
         if (take_nmi) begin
            pri_nxt   = 1'b0;
            shd_nxt   = (instr_op == CIE_OP_ENABLE) ? 1'b1 :
                        (instr_op == CIE_OP_DISABLE) ? 1'b0 : shd_r;
            state_nxt = CIE_ST_NMI;
         end else if (take_int) begin
            pri_nxt   = 1'b0;
            shd_nxt   = 1'b0;
            state_nxt = CIE_ST_INT;
         end
      end
   end

   always_comb begin
      rst_addr_nxt = rst_addr_r;
      rst_vld_nxt  = 1'b0;
      if (take_nmi) begin
         rst_addr_nxt = CIE_NMI_VECTOR;
         rst_vld_nxt  = 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         nmi_prev_r <= 1'b0;
         nmi_pend_r <= 1'b0;
      end else begin
         nmi_prev_r <= nmi_prev_nxt;
         nmi_pend_r <= nmi_pend_nxt;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         pri_r     <= CIE_ENABLE_RESET;
         shd_r     <= CIE_ENABLE_RESET;
         en_hold_r <= 1'b0;
         par_r     <= 1'b0;
         par_ld_r  <= 1'b0;
         state_r   <= CIE_ST_RUN;
      end else begin
         pri_r     <= pri_nxt;
         shd_r     <= shd_nxt;
         en_hold_r <= en_hold_nxt;
         par_r     <= par_nxt;
         par_ld_r  <= par_ld_nxt;
         state_r   <= state_nxt;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         rst_addr_r <= 16'h0000;
         rst_vld_r  <= 1'b0;
      end else begin
         rst_addr_r <= rst_addr_nxt;
         rst_vld_r  <= rst_vld_nxt;
      end
   end

   assign int_enable_primary = pri_r;
   assign int_enable_shadow  = shd_r;
   assign accept_nmi         = (state_r == CIE_ST_NMI);
   assign accept_int         = (state_r == CIE_ST_INT);
   assign restart_addr       = rst_addr_r;
   assign restart_valid      = rst_vld_r;
   assign parity_flag        = par_r;
   assign parity_load        = par_ld_r;

   // Checker-only count of boundaries since the last enable, saturating
   always_comb begin
      bnd_cnt_nxt = bnd_cnt_r;
      if (instr_done) begin
         if (instr_op == CIE_OP_ENABLE) begin
            bnd_cnt_nxt = 2'h0;
         end else if (bnd_cnt_r != 2'h2) begin
            bnd_cnt_nxt = bnd_cnt_r + 2'h1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         bnd_cnt_r <= 2'h2;
      end else begin
         bnd_cnt_r <= bnd_cnt_nxt;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   AST_NMI_ALWAYS: assert property (
      instr_done && nmi_pend_r |=> accept_nmi)
      else $error("pending nmi not accepted at boundary");
   AST_NMI_EDGE: assert property (
      instr_done && nmi_req_s && !nmi_prev_r |=> accept_nmi)
      else $error("fresh nmi not accepted at boundary");
   AST_NMI_FIRST: assert property (
      instr_done && (nmi_pend_r || (nmi_req_s && !nmi_prev_r)) |=> !accept_int)
      else $error("maskable taken over a non-maskable request");
   AST_INT_MASKED: assert property (
      accept_int |-> $past(pri_r) && !$past(en_hold_r))
      else $error("maskable accepted while disabled");
   AST_SHADOW_QUIET: assert property (
      !instr_done |=> $stable(shd_r))
      else $error("shadow changed off a boundary");
   AST_SHADOW_HOLD: assert property (
      instr_done && instr_op != CIE_OP_ENABLE && instr_op != CIE_OP_DISABLE && !take_int
      |=> $stable(shd_r))
      else $error("shadow changed without enable, disable or acceptance");
   AST_RESET_CLEAR: assert property (
      $fell(rst) |-> !pri_r && !shd_r)
      else $error("enables not clear after reset");
   AST_EI_SETS: assert property (
      instr_done && instr_op == CIE_OP_ENABLE && !take_nmi |=> pri_r && shd_r)
      else $error("enable did not set both flops");
   AST_EI_DELAY: assert property (
      instr_done && instr_op == CIE_OP_ENABLE |=> !accept_int ##1 !accept_int)
      else $error("maskable accepted right after enable");
   AST_EI_NEXT: assert property (
      instr_done && bnd_cnt_r == 2'h0 |=> !accept_int)
      else $error("maskable accepted at the boundary after enable");
   AST_DI_CLEARS: assert property (
      instr_done && instr_op == CIE_OP_DISABLE |=> !pri_r && !shd_r)
      else $error("disable did not clear both flops");
   AST_INT_CLEARS: assert property (
      accept_int |-> !pri_r && !shd_r)
      else $error("maskable acceptance left enables set");
   AST_NMI_KEEPS: assert property (
      instr_done && take_nmi && instr_op == CIE_OP_OTHER |=> !pri_r && $stable(shd_r))
      else $error("nmi acceptance disturbed shadow");
   AST_PARITY: assert property (
      parity_load |-> parity_flag == $past(shd_r))
      else $error("parity not loaded from shadow");
   AST_ACC_LOAD: assert property (
      instr_done && (instr_op == CIE_OP_LD_VBASE || instr_op == CIE_OP_LD_REFR) |=> parity_load)
      else $error("accumulator load did not load parity");
   AST_PARITY_HOLD: assert property (
      $changed(parity_flag) |-> parity_load)
      else $error("parity changed without an accumulator load");
   AST_RETURN_FROM_NONMASKABLE: assert property (
      instr_done && instr_op == CIE_OP_NMI_RETURN && !take_nmi
      |=> pri_r == $past(shd_r) && $stable(shd_r))
      else $error("return did not restore primary");
   AST_VECTOR: assert property (
      accept_nmi |-> restart_valid && restart_addr == CIE_NMI_VECTOR)
      else $error("nmi restart vector wrong");
   AST_RESTART_ONLY: assert property (
      restart_valid |-> accept_nmi)
      else $error("restart raised without nmi acceptance");
   AST_BOUNDARY: assert property (
      accept_int || accept_nmi |-> $past(instr_done))
      else $error("acceptance off an instruction boundary");
   AST_PRI_QUIET: assert property (
      !instr_done |=> $stable(pri_r))
      else $error("primary changed off a boundary");

   COV_NMI: cover property (accept_nmi);
   COV_INT: cover property (accept_int);
   COV_RETURN_FROM_NONMASKABLE_RESTORE: cover property (accept_nmi ##[1:20] (pri_r && instr_done));
   COV_PARITY: cover property (parity_load && parity_flag);
   COV_NMI_OVER_INT: cover property (accept_nmi && int_req_s);
endmodule
`default_nettype wire

// file: verification/cie_periph.sv
`default_nettype none
module cie_periph (
   input  wire logic clk,
   input  wire logic want_int,
   input  wire logic want_nmi,
   output logic      int_req_n,
   output logic      nmi_req_n
);
   timeunit 1ns;
   timeprecision 100ps;
   // Lines are pulled up, so a released request reads high
   initial begin
      int_req_n = 1'b1;
      nmi_req_n = 1'b1;
      forever begin
         @(posedge clk);
         int_req_n <= ~want_int;
         nmi_req_n <= ~want_nmi;
      end
   end
endmodule
`default_nettype wire

// file: verification/test_cpu_interrupt_enable_logic.sv
`default_nettype none
module test_cpu_interrupt_enable_logic
   import cie_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   logic                clk, rst, want_int, want_nmi, instr_done;
   logic [CIE_OP_W-1:0] instr_op;
   wire logic           int_req_n, nmi_req_n, pri, shd, a_nmi, a_int, r_val, par, p_ld;
   wire logic [15:0]    r_addr;
   int                  num_errors, compares;

   cie_periph far_side (.clk(clk), .want_int(want_int), .want_nmi(want_nmi),
      .int_req_n(int_req_n), .nmi_req_n(nmi_req_n));
   cie_enable_logic uut (.clk(clk), .rst(rst), .int_req_n(int_req_n),
      .nmi_req_n(nmi_req_n), .instr_done(instr_done), .instr_op(instr_op),
      .int_enable_primary(pri), .int_enable_shadow(shd), .accept_nmi(a_nmi),
      .accept_int(a_int), .restart_addr(r_addr), .restart_valid(r_val),
      .parity_flag(par), .parity_load(p_ld));

   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   task automatic chk(input logic ok, input string what);
      compares++;
      if (ok !== 1'b1) begin
         num_errors++;
         $display("BAD %0t %s", $time, what);
      end
   endtask

   // One instruction boundary; the answer is visible when this returns
   task automatic step(input logic [CIE_OP_W-1:0] op);
      @(posedge clk) #1;
      instr_done = 1'b1;
      instr_op = op;
      @(posedge clk) #1;
      instr_done = 1'b0;
      instr_op = CIE_OP_NONE;
   endtask

   // Enable and the next instruction end on back-to-back edges
   task automatic burst;
      @(posedge clk) #1;
      instr_done = 1'b1;
      instr_op = CIE_OP_ENABLE;
      @(posedge clk) #1;
      instr_op = CIE_OP_OTHER;
      @(posedge clk) #1;
      instr_done = 1'b0;
      instr_op = CIE_OP_NONE;
   endtask

   task automatic idle(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   // Request held long enough to pass the synchroniser, then released
   task automatic pulse_nmi;
      want_nmi = 1'b1;
      idle(3);
      want_nmi = 1'b0;
      idle(3);
   endtask

   task automatic t_reset;
      chk(pri === 1'b0 && shd === 1'b0 && a_int === 1'b0 && a_nmi === 1'b0, "reset");
      $display("test reset done");
   endtask

   task automatic t_masked;
      want_int = 1'b1;
      idle(3);
      step(CIE_OP_OTHER);
      chk(a_int === 1'b0, "taken while disabled");
      step(CIE_OP_ENABLE);
      step(CIE_OP_DISABLE);
      chk(pri === 1'b0 && shd === 1'b0, "disable");
      step(CIE_OP_OTHER);
      step(CIE_OP_OTHER);
      chk(a_int === 1'b0, "taken after disable");
      $display("test masked done");
   endtask

   task automatic t_enable;
      step(CIE_OP_ENABLE);
      chk(pri === 1'b1 && shd === 1'b1 && a_int === 1'b0, "enable");
      idle(3);
      chk(a_int === 1'b0, "taken off boundary");
      step(CIE_OP_OTHER);
      chk(a_int === 1'b0, "taken right after enable");
      step(CIE_OP_OTHER);
      chk(a_int === 1'b1 && pri === 1'b0 && shd === 1'b0, "maskable accept");
      want_int = 1'b0;
      idle(4);
      $display("test enable done");
   endtask

   task automatic t_nmi;
      step(CIE_OP_ENABLE);
      step(CIE_OP_OTHER);
      pulse_nmi();
      chk(a_nmi === 1'b0, "nmi taken off boundary");
      step(CIE_OP_OTHER);
      chk(a_nmi === 1'b1 && r_val === 1'b1 && r_addr === CIE_NMI_VECTOR, "restart");
      chk(pri === 1'b0 && shd === 1'b1, "nmi flops");
      step(CIE_OP_LD_VBASE);
      chk(p_ld === 1'b1 && par === 1'b1, "parity from vector base");
      step(CIE_OP_NMI_RETURN);
      chk(pri === 1'b1 && shd === 1'b1, "return restores");
      step(CIE_OP_DISABLE);
      pulse_nmi();
      step(CIE_OP_OTHER);
      chk(a_nmi === 1'b1 && pri === 1'b0 && shd === 1'b0, "nmi while disabled");
      step(CIE_OP_LD_REFR);
      chk(p_ld === 1'b1 && par === 1'b0, "parity from refresh");
      $display("test nmi done");
   endtask

   task automatic t_burst;
      want_int = 1'b1;
      idle(3);
      burst();
      chk(a_int === 1'b0 && pri === 1'b1 && shd === 1'b1, "held after enable");
      step(CIE_OP_OTHER);
      chk(a_int === 1'b1 && pri === 1'b0 && shd === 1'b0, "accept after hold");
      want_int = 1'b0;
      idle(4);
      $display("test burst done");
   endtask

   task automatic t_priority;
      step(CIE_OP_ENABLE);
      step(CIE_OP_OTHER);
      want_int = 1'b1;
      pulse_nmi();
      step(CIE_OP_OTHER);
      chk(a_nmi === 1'b1 && a_int === 1'b0, "nmi beats maskable");
      chk(pri === 1'b0 && shd === 1'b1, "shadow kept");
      step(CIE_OP_OTHER);
      chk(a_int === 1'b0, "taken after nmi");
      step(CIE_OP_NMI_RETURN);
      chk(pri === 1'b1 && shd === 1'b1 && a_int === 1'b0, "return restores");
      step(CIE_OP_OTHER);
      chk(a_int === 1'b1 && pri === 1'b0 && shd === 1'b0, "accept after return");
      want_int = 1'b0;
      idle(4);
      $display("test priority done");
   endtask

   task automatic conclude;
      $display("Comparisons %0d mismatches %0d", compares, num_errors);
      if (num_errors == 0 && compares > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   initial begin
      rst = 1'b1;
      want_int = 1'b0;
      want_nmi = 1'b0;
      instr_done = 1'b0;
      instr_op = CIE_OP_NONE;
      num_errors = 0;
      compares = 0;
      repeat (4) @(posedge clk);
      #1;
      rst = 1'b0;
      idle(1);
      t_reset();
      t_masked();
      t_enable();
      t_nmi();
      t_burst();
      t_priority();
      conclude();
   end
endmodule
`default_nettype wire
